// >>> logic/adc_control.sv
// converter control: enable, start, auto trigger, done flag, prescaler,
// result pair with justification and low-then-high read lock
// assumes apb master on pclk; analog result, trigger flags and pins are async
`default_nettype none

module adc_control
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // analog front end and trigger sources
  input  wire logic [9:0]  analog_result,
  input  wire logic [11:0] trigger_flags,
  output logic             converter_on,
  output logic             fast_mode,
  output logic      [5:0]  channel_select,
  // processor side
  input  wire logic        global_irq_enable,
  input  wire logic        irq_vector_ack,
  output logic             conv_irq,
  // port pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_read
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  ctrl_a_t     ctrl_a_reg;
  ctrl_b_t     ctrl_b_reg;
  logic [7:0]  mux_reg;
  logic [7:0]  in_dis_reg;
  logic [9:0]  result_reg;
  logic        lock_reg;
  logic        flag_reg;
  logic        init_reg;
  conv_state_t state_reg;
  logic [6:0]  pre_cnt_reg;
  logic [4:0]  conv_cnt_reg;
  logic        sel_prev_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        irq_reg;
  logic [7:0]  pin_read_reg;

  logic [9:0]  ana_s1_reg;
  logic [9:0]  ana_s2_reg;
  logic [11:0] trig_s1_reg;
  logic [11:0] trig_s2_reg;
  logic [7:0]  pin_s1_reg;
  logic [7:0]  pin_s2_reg;

  logic        addr_ok;
  logic        setup_cyc;
  logic        wr_en;
  logic        wr_a;
  logic        setup_rd;
  logic [7:0]  rdata_next;
  logic [6:0]  div_max;
  logic        tick;
  logic [4:0]  target;
  logic        done;
  logic        done_upd;
  logic        sel_flag;
  logic        trig_evt;
  logic        sw_start;
  logic        free_restart;
  logic        start_req;
  logic        busy;
  logic [9:0]  result_next;
  logic [7:0]  res_high;
  logic [7:0]  res_low;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [6:0] div_limit(input logic [2:0] code);
    logic [7:0] ratio;
    ratio = 8'h01 << code;
    if (code < 3'h2) begin
      div_limit = 7'h01;
    end else begin
      div_limit = 7'(ratio - 8'h01);
    end
  endfunction : div_limit

  // single-ended codes; every other code is a differential pair
  function automatic logic is_diff(input logic [5:0] code);
    is_diff = !((code <= 6'h07) || (code == 6'h1E) || (code == 6'h1F) ||
                ((code >= 6'h20) && (code <= 6'h25)) || (code == 6'h27));
  endfunction : is_diff

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_s1_reg  <= 10'h000;
      ana_s2_reg  <= 10'h000;
      trig_s1_reg <= 12'h000;
      trig_s2_reg <= 12'h000;
      pin_s1_reg  <= 8'h00;
      pin_s2_reg  <= 8'h00;
    end else begin
      ana_s1_reg  <= analog_result;
      ana_s2_reg  <= ana_s1_reg;
      trig_s1_reg <= trigger_flags;
      trig_s2_reg <= trig_s1_reg;
      pin_s1_reg  <= pin_in;
      pin_s2_reg  <= pin_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb decode; no wait states, data latched in setup

  assign addr_ok   = (paddr == OFF_CTRL_A) || (paddr == OFF_CTRL_B) ||
                     (paddr == OFF_RES_LOW) || (paddr == OFF_RES_HIGH) ||
                     (paddr == OFF_MUX) || (paddr == OFF_IN_DIS);
  assign setup_cyc = psel && !penable;
  assign setup_rd  = setup_cyc && !pwrite;
  assign wr_en     = psel && penable && pready_reg && pwrite && pstrb[0] && addr_ok;
  assign wr_a      = wr_en && (paddr == OFF_CTRL_A);

  always_comb begin
    rdata_next = 8'h00;
    unique case (paddr)
      OFF_CTRL_A:   rdata_next = {ctrl_a_reg.en, busy, ctrl_a_reg.ate, flag_reg,
                                  ctrl_a_reg.ie, ctrl_a_reg.div};
      OFF_CTRL_B:   rdata_next = ctrl_b_reg;
      OFF_RES_LOW:  rdata_next = res_low;
      OFF_RES_HIGH: rdata_next = res_high;
      OFF_MUX:      rdata_next = mux_reg;
      OFF_IN_DIS:   rdata_next = in_dis_reg;
      default:      rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= setup_cyc && !pready_reg;
      pslverr_reg <= setup_cyc && !addr_ok;
      if (setup_rd) begin
        prdata_reg <= {24'h000000, rdata_next};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register a

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg <= ctrl_a_t'(CTRL_A_RST);
    end else if (wr_a) begin
      ctrl_a_reg.en    <= pwdata[BIT_EN];
      ctrl_a_reg.ate   <= pwdata[BIT_ATE];
      ctrl_a_reg.ie    <= pwdata[BIT_IE];
      ctrl_a_reg.div   <= pwdata[2:0];
      ctrl_a_reg.start <= 1'b0;
      ctrl_a_reg.flag  <= 1'b0;
    end
  end

  // done flag: set wins over vector or software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;
    end else if (done_upd) begin
      flag_reg <= 1'b1;
    end else if ((wr_a && pwdata[BIT_FLAG]) || irq_vector_ack) begin
      flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register b, channel mux, input disable

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_reg <= ctrl_b_t'(CTRL_B_RST);
    end else if (wr_en && (paddr == OFF_CTRL_B)) begin
      ctrl_b_reg      <= ctrl_b_t'(pwdata[7:0]);
      ctrl_b_reg.rsv  <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_reg <= MUX_RST;
    end else if (wr_en && (paddr == OFF_MUX)) begin
      mux_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_dis_reg <= IN_DIS_RST;
    end else if (wr_en && (paddr == OFF_IN_DIS)) begin
      in_dis_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_read_reg <= 8'h00;
    end else begin
      pin_read_reg <= pin_s2_reg & ~in_dis_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler

  assign div_max = div_limit(ctrl_a_reg.div);
  assign tick    = ctrl_a_reg.en && (pre_cnt_reg >= div_max);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= 7'h00;
    end else if (!ctrl_a_reg.en || tick) begin
      pre_cnt_reg <= 7'h00;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start sources

  always_comb begin
    sel_flag = 1'b0;
    if ((ctrl_b_reg.trig != TRIG_FREE) && (ctrl_b_reg.trig <= TRIG_LAST)) begin
      sel_flag = trig_s2_reg[ctrl_b_reg.trig];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_prev_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_flag;
    end
  end

  assign trig_evt     = ctrl_a_reg.en && ctrl_a_reg.ate &&
                        sel_flag && !sel_prev_reg;
  assign sw_start     = wr_a && pwdata[BIT_START] && pwdata[BIT_EN];
  assign free_restart = done && ctrl_a_reg.ate &&
                        (ctrl_b_reg.trig == TRIG_FREE);
  assign start_req    = sw_start || trig_evt || free_restart;

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  assign target   = init_reg ? FIRST_CYCLES : NORMAL_CYCLES;
  assign done     = (state_reg == ST_CONV) && ctrl_a_reg.en && tick &&
                    (conv_cnt_reg == target - 5'h01);
  // a completion on the low-byte read edge is dropped, keeping the pair whole
  assign done_upd = done && !lock_reg &&
                    !(setup_rd && (paddr == OFF_RES_LOW));
  assign busy     = (state_reg == ST_CONV) && ctrl_a_reg.en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_IDLE;
      conv_cnt_reg <= 5'h00;
    end else if (!ctrl_a_reg.en && !sw_start) begin
      state_reg    <= ST_IDLE;
      conv_cnt_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            state_reg    <= ST_CONV;
            conv_cnt_reg <= 5'h00;
          end
        end
        ST_CONV: begin
          if (done) begin
            state_reg    <= free_restart ? ST_CONV : ST_IDLE;
            conv_cnt_reg <= 5'h00;
          end else if (tick) begin
            conv_cnt_reg <= conv_cnt_reg + 5'h01;
          end
        end
      endcase
    end
  end

  // first conversion after enabling carries initialisation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_reg <= 1'b1;
    end else if (!ctrl_a_reg.en && !sw_start) begin
      init_reg <= 1'b1;
    end else if (done) begin
      init_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result capture and read lock

  assign result_next = is_diff(channel_select) ?
                       (ana_s2_reg ^ 10'h200) : ana_s2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= RESULT_RST;
    end else if (done_upd) begin
      result_reg <= result_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= 1'b0;
    end else if (setup_rd && (paddr == OFF_RES_HIGH)) begin
      lock_reg <= 1'b0;
    end else if (setup_rd && (paddr == OFF_RES_LOW)) begin
      lock_reg <= 1'b1;
    end
  end

  always_comb begin
    if (mux_reg[BIT_LJUST]) begin
      res_high = result_reg[9:2];
      res_low  = {result_reg[1:0], 6'h00};
    end else begin
      res_high = {6'h00, result_reg[9:8]};
      res_low  = result_reg[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt request

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag_reg && ctrl_a_reg.ie && global_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign converter_on   = ctrl_a_reg.en;
  assign fast_mode      = ctrl_b_reg.fast;
  assign channel_select = {ctrl_b_reg.top, mux_reg[4:0]};
  assign conv_irq       = irq_reg;
  assign pin_read       = pin_read_reg;

endmodule : adc_control

`default_nettype wire

// >>> pkg/adc_ctrl_pkg.sv
// constants, register map and field carriers for the converter control block
// assumes a 32-bit apb slave on pclk; only byte lane 0 carries register data
`default_nettype none

package adc_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL_A   = 8'h00;
  localparam logic [7:0] OFF_CTRL_B   = 8'h04;
  localparam logic [7:0] OFF_RES_LOW  = 8'h08;
  localparam logic [7:0] OFF_RES_HIGH = 8'h0C;
  localparam logic [7:0] OFF_MUX      = 8'h10;
  localparam logic [7:0] OFF_IN_DIS   = 8'h14;

  // field positions
  localparam int BIT_EN    = 7;
  localparam int BIT_START = 6;
  localparam int BIT_ATE   = 5;
  localparam int BIT_FLAG  = 4;
  localparam int BIT_IE    = 3;
  localparam int BIT_FAST  = 7;
  localparam int BIT_TOP   = 5;
  localparam int BIT_LJUST = 5;

  // values after reset
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] MUX_RST    = 8'h00;
  localparam logic [7:0] IN_DIS_RST = 8'h00;
  localparam logic [9:0] RESULT_RST = 10'h000;

  // conversion lengths in converter clock cycles
  localparam logic [4:0] NORMAL_CYCLES = 5'h0D;
  localparam logic [4:0] FIRST_CYCLES  = 5'h19;

  // trigger codes
  localparam logic [3:0] TRIG_FREE = 4'h0;
  localparam logic [3:0] TRIG_LAST = 4'hB;

  typedef struct packed {
    logic       en;
    logic       start;
    logic       ate;
    logic       flag;
    logic       ie;
    logic [2:0] div;
  } ctrl_a_t;

  typedef struct packed {
    logic       fast;
    logic       comp_mux;
    logic       top;
    logic       rsv;
    logic [3:0] trig;
  } ctrl_b_t;

  typedef enum logic {ST_IDLE, ST_CONV} conv_state_t;

endpackage : adc_ctrl_pkg

`default_nettype wire

// >>> verif/adc_control_monitor.sv
// concurrent checks on the converter control block ports
// assumes single pclk domain, presetn async active low
`default_nettype none

module adc_control_monitor
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // converter side
  input wire logic [9:0]  analog_result,
  input wire logic [11:0] trigger_flags,
  input wire logic        converter_on,
  input wire logic        fast_mode,
  input wire logic [5:0]  channel_select,
  input wire logic        global_irq_enable,
  input wire logic        irq_vector_ack,
  input wire logic        conv_irq,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_read
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       wr;
  logic       rd;
  logic       en_reg;
  logic       fast_reg;
  logic       lj_reg;
  logic [5:0] chan_reg;
  logic [7:0] didr_reg;

  assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  assign rd = psel && penable && pready && !pwrite;

  // shadow copies of written fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg   <= 1'b0;
      fast_reg <= 1'b0;
      lj_reg   <= 1'b0;
      chan_reg <= 6'h00;
      didr_reg <= 8'h00;
    end else if (wr) begin
      if (paddr == OFF_CTRL_A) en_reg <= pwdata[BIT_EN];
      if (paddr == OFF_CTRL_B) fast_reg <= pwdata[BIT_FAST];
      if (paddr == OFF_CTRL_B) chan_reg[5] <= pwdata[BIT_TOP];
      if (paddr == OFF_MUX) chan_reg[4:0] <= pwdata[4:0];
      if (paddr == OFF_MUX) lj_reg <= pwdata[BIT_LJUST];
      if (paddr == OFF_IN_DIS) didr_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held two cycles");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("slverr without ready");
  a_read_upper_zero: assert property (rd |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
  a_enable_follows: assert property (wr && paddr == OFF_CTRL_A |-> ##[1:2] converter_on == en_reg)
    else $error("converter_on not following enable");
  a_fast_follows: assert property (wr && paddr == OFF_CTRL_B |-> ##[1:2] fast_mode == fast_reg)
    else $error("fast_mode not following write");
  a_chan_follows: assert property (wr && (paddr == OFF_MUX || paddr == OFF_CTRL_B)
    |-> ##[1:2] channel_select == chan_reg) else $error("channel code mismatch");
  a_irq_needs_global: assert property (conv_irq |-> $past(global_irq_enable))
    else $error("irq without global enable");
  a_start_means_on: assert property (rd && paddr == OFF_CTRL_A && prdata[BIT_START] |-> converter_on)
    else $error("start set while converter off");
  a_right_just: assert property (rd && paddr == OFF_RES_HIGH && !lj_reg |-> prdata[7:2] == 6'h00)
    else $error("right justified high byte bits set");
  a_left_just: assert property (rd && paddr == OFF_RES_LOW && lj_reg |-> prdata[5:0] == 6'h00)
    else $error("left justified low byte bits set");
  a_pin_masked: assert property ((pin_read & didr_reg & $past(didr_reg) & $past(didr_reg, 2)) == 8'h00)
    else $error("disabled pin reads one");

endmodule : adc_control_monitor

bind adc_control adc_control_monitor mon_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .analog_result(analog_result), .trigger_flags(trigger_flags), .converter_on(converter_on),
  .fast_mode(fast_mode), .channel_select(channel_select), .global_irq_enable(global_irq_enable),
  .irq_vector_ack(irq_vector_ack), .conv_irq(conv_irq), .pin_in(pin_in), .pin_read(pin_read)
);

`default_nettype wire

// >>> verif/adc_control_tb.sv
// self-checking bench for the converter control block
// assumes adc_control with apb on pclk; read results checked from a queue
`default_nettype none

module adc_control_tb
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("BAD %0t %h %h", $time, a, b); end end

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        converter_on, fast_mode, glob, ack, conv_irq;
  logic [7:0]  paddr, pin_in, pin_read, d;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, strb;
  logic [9:0]  analog, r;
  logic [11:0] trig;
  logic [5:0]  chan;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          err_count, checks;

  adc_control dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_result(analog), .trigger_flags(trig), .converter_on(converter_on), .fast_mode(fast_mode),
    .channel_select(chan), .global_irq_enable(glob), .irq_vector_ack(ack), .conv_irq(conv_irq),
    .pin_in(pin_in), .pin_read(pin_read)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] x);
    int n;
    n = 0;
    @(posedge pclk);
    if (!w) exp_q.push_back(x);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      conclude();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    apb(1'b0, a, 32'h0, x);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v}, 33'h0);
  endtask : wr

  // one read while running, one after completion
  task automatic await2(input logic [7:0] mid, input logic [7:0] fin);
    repeat (40) @(posedge pclk);
    rd(OFF_CTRL_A, {25'h0, mid});
    repeat (30) @(posedge pclk);
    rd(OFF_CTRL_A, {25'h0, fin});
  endtask : await2

  task automatic conv(input logic [7:0] w, input logic [7:0] mid, input logic [7:0] fin);
    wr(OFF_CTRL_A, w);
    await2(mid, fin);
  endtask : conv

  // result checker: oldest note against each read answer
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        err_count++;
      end else begin
        e = exp_q.pop_front();
        `CHK({pslverr, prdata}, e)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, glob, ack, trig} = '0;
    strb = 4'hF;
    pstrb = 4'hF;
    void'($urandom(32'hA7EA4431));
    analog = 10'($urandom);
    pin_in = 8'($urandom);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 33'h0);
    rd(8'h18, 33'h1_0000_0000);
    r = analog;
    conv(8'hC1, 8'hC1, 8'h91);
    rd(OFF_RES_LOW, {25'h0, r[7:0]});
    rd(OFF_RES_HIGH, {31'h0, r[9:8]});
    analog <= 10'($urandom);
    conv(8'hD2, 8'hC2, 8'h92);
    r = analog;
    wr(OFF_MUX, 8'h20);
    rd(OFF_RES_LOW, {25'h0, r[1:0], 6'h00});
    analog <= ~analog;
    conv(8'hD2, 8'hC2, 8'h82);
    rd(OFF_RES_HIGH, {25'h0, r[9:2]});
    conv(8'hD2, 8'hC2, 8'h92);
    rd(OFF_RES_HIGH, {25'h0, ~r[9:2]});
    rd(OFF_RES_LOW, {25'h0, ~r[1:0], 6'h00});
    rd(OFF_RES_HIGH, {25'h0, ~r[9:2]});
    wr(OFF_CTRL_A, 8'h8A);
    repeat (3) @(posedge pclk);
    `CHK(conv_irq, 1'b0)
    glob <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(conv_irq, 1'b1)
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(conv_irq, 1'b0)
    rd(OFF_CTRL_A, 33'h8A);
    // divide by 128: 13 ticks land between 1661 and 1664 cycles
    wr(OFF_CTRL_A, 8'hD7);
    repeat (1500) @(posedge pclk);
    rd(OFF_CTRL_A, {25'h0, 8'hC7});
    repeat (170) @(posedge pclk);
    rd(OFF_CTRL_A, {25'h0, 8'h97});
    // pass 0 (trigger code 3) runs with auto trigger off
    for (int i = 0; i < 12; i++) begin
      wr(OFF_CTRL_A, i == 0 ? 8'h92 : 8'hB2);
      if (i % 2) trig[i] <= 1'b1;
      wr(OFF_CTRL_B, {i[0], 1'b0, i[1], 1'b0, i == 0 ? 4'h3 : 4'(i)});
      trig[i == 0 ? 3 : i] <= 1'b1;
      if (i == 0) await2(8'h82, 8'h82);
      else await2(8'hE2, 8'hB2);
      trig <= 12'h000;
    end
    wr(OFF_CTRL_B, 8'h00);
    await2(8'hB2, 8'hB2);
    conv(8'hF2, 8'hE2, 8'hF2);
    wr(OFF_CTRL_A, 8'h12);
    repeat (3) @(posedge pclk);
    `CHK(converter_on, 1'b0)
    await2(8'h02, 8'h02);
    // differential code 09, left justified: sign bit inverted
    wr(OFF_MUX, 8'h29);
    r = analog ^ 10'h200;
    wr(OFF_CTRL_A, 8'hD2);
    repeat (130) @(posedge pclk);
    rd(OFF_RES_LOW, {25'h0, r[1:0], 6'h00});
    rd(OFF_RES_HIGH, {25'h0, r[9:2]});
    d = 8'($urandom);
    wr(OFF_IN_DIS, d);
    rd(OFF_IN_DIS, {25'h0, d});
    repeat (4) @(posedge pclk);
    `CHK(pin_read, pin_in & ~d)
    strb = 4'h0;
    wr(OFF_IN_DIS, ~d);
    strb = 4'hF;
    rd(OFF_IN_DIS, {25'h0, d});
    wr(OFF_MUX, 8'($urandom) & 8'h1F);
    repeat (4) @(posedge pclk);
    conclude();
  end

endmodule : adc_control_tb

`default_nettype wire
